// ### common/irq_route_pkg.sv
// Package with register offsets, field positions and carrier structs for the bridge interrupt block.
`default_nettype none
package irq_route_pkg;

    // Byte offsets within the bridge register window.
    localparam logic [7:0] ROUTE_STATUS_OFS  = 8'h48;
    localparam logic [7:0] LOCAL_STATUS_OFS  = 8'h76;
    localparam logic [7:0] LOCAL_MASK_OFS    = 8'h77;
    localparam logic [7:0] MBOX_WR_EN_OFS    = 8'hd0;
    localparam logic [7:0] MBOX_RD_EN_OFS    = 8'hd2;
    localparam logic [7:0] MBOX_WR_STAT_OFS  = 8'hd8;
    localparam logic [7:0] MBOX_RD_STAT_OFS  = 8'hda;

    // Local status and mask bit positions.
    localparam int LOC_MAILBOX_BIT = 7;
    localparam int LOC_RD_ERR_BIT  = 6;
    localparam int LOC_WR_ERR_BIT  = 5;
    localparam int LOC_HOST_BIT    = 4;
    localparam int LOC_PERR_BIT    = 3;
    localparam int LOC_POST_BIT    = 2;
    localparam int LOC_XFER1_BIT   = 1;
    localparam int LOC_XFER0_BIT   = 0;

    // Route status bit positions in the host interrupt status word.
    localparam int LINE_C_TO_D_BIT = 14;
    localparam int LINE_B_TO_D_BIT = 13;
    localparam int LINE_A_TO_D_BIT = 12;
    localparam int LINE_D_TO_C_BIT = 11;
    localparam int LINE_B_TO_C_BIT = 9;
    localparam int LINE_A_TO_C_BIT = 8;
    localparam int LINE_D_TO_B_BIT = 7;
    localparam int LINE_C_TO_B_BIT = 6;
    localparam int LINE_A_TO_B_BIT = 4;
    localparam int LINE_D_TO_A_BIT = 3;
    localparam int LINE_C_TO_A_BIT = 2;
    localparam int LINE_B_TO_A_BIT = 1;

    // Reset values.
    localparam logic [7:0]  LOCAL_MASK_RST = 8'h00;
    localparam logic [15:0] MBOX_EN_RST    = 16'h0000;
    localparam int          MBOX_COUNT     = 16;

    // Register access request from the host window.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } reg_req_s;

    // Routing selections, one bit per source-to-output path (d,c,b,a order per output).
    typedef struct packed {
        logic c_to_d;
        logic b_to_d;
        logic a_to_d;
        logic d_to_c;
        logic b_to_c;
        logic a_to_c;
        logic d_to_b;
        logic c_to_b;
        logic a_to_b;
        logic d_to_a;
        logic c_to_a;
        logic b_to_a;
    } route_sel_s;

    // Bridge events feeding the local status bits other than mailbox.
    typedef struct packed {
        logic rd_err;
        logic wr_err;
        logic host_irq;
        logic host_parity_error_irq;
        logic inbound_post_write_irq;
        logic xfer_channel_one_irq;
        logic xfer_channel_zero_irq;
    } local_evt_s;

endpackage : irq_route_pkg
`default_nettype wire

// ### core/bridge_interrupt_routing_mask.sv
// Local interrupt mask/status, mailbox enables and line cross-route status of the bridge.
// Functional notes
// - Bits 13,12 show B,A routed to D.
// - Status shows D,B,A routed onto line C.
// - Status shows D,C,A routed onto line B.
// - Status shows D,C,B routed onto line A.
// - Mask bit 7 gates mailbox interrupts globally.
// - Mask bits 6,5 enable read/write error interrupts.
// - Mask bit 4 forwards host interrupt locally.
// - Mask bit 3 enables parity error interrupt.
// - Mask bit 2 enables inbound post write interrupt.
// - Mask bits 1,0 enable transfer channel interrupts.
// - Status bit 7 set while mailbox pending.
// - Enable bit n arms interrupt for mailbox n.
// - Write enables at 0xD0, read at 0xD2.
// - Write and read enables are independent.
// - Mailbox flag clears only on written one.
// - Bit 14 shows line C routed to D.
`timescale 1ns/1ps
`default_nettype none
module bridge_interrupt_routing_mask (
    input  wire logic                      clk_i,
    input  wire logic                      srst_i,
    input  wire irq_route_pkg::reg_req_s   req_i,
    output logic                           rvalid_o,
    output logic [31:0]                    rdata_o,
    input  wire irq_route_pkg::route_sel_s route_sel_i,
    input  wire logic [3:0]                line_in_n_i,
    input  wire irq_route_pkg::local_evt_s evt_i,
    input  wire logic [15:0]               mbox_wr_hit_i,
    input  wire logic [15:0]               mbox_rd_hit_i,
    output logic                           local_irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State and declarations.

    typedef struct packed {
        logic [3:0]  line_meta;
        logic [3:0]  line_sync;
        logic [7:0]  local_mask;
        logic [15:0] mbox_wr_en;
        logic [15:0] mbox_rd_en;
        logic [7:0]  evt_meta;
        logic [7:0]  evt_sync;
        logic [15:0] route_stat;
        logic        rvalid;
        logic [31:0] rdata;
        logic        irq;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic [15:0] mbox_wr_flags;
    logic [15:0] mbox_rd_flags;
    logic [7:0]  local_status;
    logic [3:0]  line_act;
    logic [15:0] route_now;
    logic [15:0] lo16;
    logic [15:0] hi16;
    logic        clr_wr;
    logic        clr_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Mailbox flag banks, one per access direction.

    // Separate enable registers arm writes and reads independently.
    assign clr_wr = req_i.wr && (req_i.addr == irq_route_pkg::MBOX_WR_STAT_OFS);
    assign clr_rd = req_i.wr && (req_i.addr == irq_route_pkg::MBOX_RD_STAT_OFS);
    assign lo16   = {(req_i.be[1] ? req_i.wdata[15:8] : 8'h00), (req_i.be[0] ? req_i.wdata[7:0] : 8'h00)};
    assign hi16   = {(req_i.be[3] ? req_i.wdata[31:24] : 8'h00), (req_i.be[2] ? req_i.wdata[23:16] : 8'h00)};

    mbox_flag_bank u_wr_bank (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .allow_i    (s_q.mbox_wr_en),
        .hit_i      (mbox_wr_hit_i),
        .clr_i      (clr_wr),
        .clr_mask_i (lo16),
        .flags_o    (mbox_wr_flags)
    );

    mbox_flag_bank u_rd_bank (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .allow_i    (s_q.mbox_rd_en),
        .hit_i      (mbox_rd_hit_i),
        .clr_i      (clr_rd),
        .clr_mask_i (lo16),
        .flags_o    (mbox_rd_flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Line routing status and local status assembly.

    // Lines are active low; use only the synchronised copy.
    assign line_act = ~s_q.line_sync;

    // A route bit reads 1 while its path is selected and the source line is active.
    always_comb begin
        route_now = 16'h0000;
        route_now[irq_route_pkg::LINE_C_TO_D_BIT] = route_sel_i.c_to_d & line_act[2];
        route_now[irq_route_pkg::LINE_B_TO_D_BIT] = route_sel_i.b_to_d & line_act[1];
        route_now[irq_route_pkg::LINE_A_TO_D_BIT] = route_sel_i.a_to_d & line_act[0];
        route_now[irq_route_pkg::LINE_D_TO_C_BIT] = route_sel_i.d_to_c & line_act[3];
        route_now[irq_route_pkg::LINE_B_TO_C_BIT] = route_sel_i.b_to_c & line_act[1];
        route_now[irq_route_pkg::LINE_A_TO_C_BIT] = route_sel_i.a_to_c & line_act[0];
        route_now[irq_route_pkg::LINE_D_TO_B_BIT] = route_sel_i.d_to_b & line_act[3];
        route_now[irq_route_pkg::LINE_C_TO_B_BIT] = route_sel_i.c_to_b & line_act[2];
        route_now[irq_route_pkg::LINE_A_TO_B_BIT] = route_sel_i.a_to_b & line_act[0];
        route_now[irq_route_pkg::LINE_D_TO_A_BIT] = route_sel_i.d_to_a & line_act[3];
        route_now[irq_route_pkg::LINE_C_TO_A_BIT] = route_sel_i.c_to_a & line_act[2];
        route_now[irq_route_pkg::LINE_B_TO_A_BIT] = route_sel_i.b_to_a & line_act[1];
    end

    // Mailbox summary is live, so it drops as soon as every flag is cleared.
    always_comb begin
        local_status = s_q.evt_sync;
        local_status[irq_route_pkg::LOC_MAILBOX_BIT] = |{mbox_wr_flags, mbox_rd_flags};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: registers, read mux and interrupt output.

    always_comb begin
        s_d           = s_q;
        s_d.line_meta = line_in_n_i;
        s_d.line_sync = s_q.line_meta;
        s_d.evt_meta  = {1'b0, evt_i};
        s_d.evt_sync  = s_q.evt_meta;
        s_d.route_stat = route_now;
        s_d.rvalid    = req_i.rd;
        s_d.rdata     = 32'h0000_0000;

        // Writes. Mask sits in byte lane 3 of the word at 0x74; the status byte next to it is read only.
        if (req_i.wr) begin
            unique case (req_i.addr)
                irq_route_pkg::LOCAL_STATUS_OFS,
                irq_route_pkg::LOCAL_MASK_OFS: begin
                    if (req_i.be[3]) begin
                        s_d.local_mask = req_i.wdata[31:24];
                    end
                end
                irq_route_pkg::MBOX_WR_EN_OFS: begin
                    // Each byte lane updates only its own byte, so a partial write keeps the other enables.
                    if (req_i.be[0]) begin
                        s_d.mbox_wr_en[7:0] = lo16[7:0];
                    end
                    if (req_i.be[1]) begin
                        s_d.mbox_wr_en[15:8] = lo16[15:8];
                    end
                    if (req_i.be[2]) begin
                        s_d.mbox_rd_en[7:0] = hi16[7:0];
                    end
                    if (req_i.be[3]) begin
                        s_d.mbox_rd_en[15:8] = hi16[15:8];
                    end
                end
                irq_route_pkg::MBOX_RD_EN_OFS: begin
                    if (req_i.be[0]) begin
                        s_d.mbox_rd_en[7:0] = lo16[7:0];
                    end
                    if (req_i.be[1]) begin
                        s_d.mbox_rd_en[15:8] = lo16[15:8];
                    end
                end
                default: begin
                end
            endcase
        end

        // Reads; the route status word ignores writes and keeps reserved bits zero.
        if (req_i.rd) begin
            unique case (req_i.addr)
                irq_route_pkg::ROUTE_STATUS_OFS: s_d.rdata = {16'h0000, s_q.route_stat};
                irq_route_pkg::LOCAL_STATUS_OFS,
                irq_route_pkg::LOCAL_MASK_OFS:   s_d.rdata = {s_q.local_mask, local_status, 16'h0000};
                irq_route_pkg::MBOX_WR_EN_OFS:   s_d.rdata = {s_q.mbox_rd_en, s_q.mbox_wr_en};
                irq_route_pkg::MBOX_RD_EN_OFS:   s_d.rdata = {16'h0000, s_q.mbox_rd_en};
                irq_route_pkg::MBOX_WR_STAT_OFS: s_d.rdata = {mbox_rd_flags, mbox_wr_flags};
                irq_route_pkg::MBOX_RD_STAT_OFS: s_d.rdata = {16'h0000, mbox_rd_flags};
                default:                         s_d.rdata = 32'h0000_0000;
            endcase
        end

        // Bits 7..0 each pair a status with its mask; bit 7 is the global mailbox gate.
        s_d.irq = |(local_status & s_q.local_mask);
    end

    // Single register stage for all state.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q            <= '0;
            s_q.line_meta  <= 4'hf;
            s_q.line_sync  <= 4'hf;
            s_q.local_mask <= irq_route_pkg::LOCAL_MASK_RST;
            s_q.mbox_wr_en <= irq_route_pkg::MBOX_EN_RST;
            s_q.mbox_rd_en <= irq_route_pkg::MBOX_EN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rvalid_o    = s_q.rvalid;
    assign rdata_o     = s_q.rdata;
    assign local_irq_o = s_q.irq;

endmodule : bridge_interrupt_routing_mask
`default_nettype wire

// ### core/mbox_flag_bank.sv
// Sticky per-mailbox flag bank with write-one-to-clear and set-over-clear priority.
`timescale 1ns/1ps
`default_nettype none
module mbox_flag_bank (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic [15:0] allow_i,
    input  wire logic [15:0] hit_i,
    input  wire logic        clr_i,
    input  wire logic [15:0] clr_mask_i,
    output logic      [15:0] flags_o
);

    typedef struct packed {
        logic [15:0] flags;
    } bank_s;

    bank_s s_q;
    bank_s s_d;

    // A fresh access wins over a same-cycle clear so no event is lost.
    always_comb begin
        s_d = s_q;
        if (clr_i) begin
            s_d.flags = s_q.flags & ~clr_mask_i;
        end
        s_d.flags = s_d.flags | (hit_i & allow_i);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags_o = s_q.flags;

endmodule : mbox_flag_bank
`default_nettype wire

// ### testbench/bridge_interrupt_routing_mask_tb.sv
// Self-checking bench for the bridge interrupt routing and mask block.
`timescale 1ns/1ps
`default_nettype none
module bridge_interrupt_routing_mask_tb;
    logic                      clk_i;
    logic                      srst_i;
    irq_route_pkg::reg_req_s   req;
    irq_route_pkg::route_sel_s sel;
    logic                      rvalid_o;
    logic [31:0]               rdata_o;
    logic [3:0]                line_n;
    irq_route_pkg::local_evt_s evt;
    logic [15:0]               wr_hit;
    logic [15:0]               rd_hit;
    logic                      local_irq_o;
    int                        errors;
    int                        num_checks;
    // Source line and status position of each path, struct bit 11 first.
    int src_tbl [12] = '{2, 1, 0, 3, 1, 0, 3, 2, 0, 3, 2, 1};
    int pos_tbl [12] = '{14, 13, 12, 11, 9, 8, 7, 6, 4, 3, 2, 1};
    bridge_interrupt_routing_mask bridge_interrupt_routing_mask_inst (.clk_i, .srst_i, .req_i(req), .rvalid_o,
        .rdata_o, .route_sel_i(sel), .line_in_n_i(line_n), .evt_i(evt), .mbox_wr_hit_i(wr_hit),
        .mbox_rd_hit_i(rd_hit), .local_irq_o);
    host_side_model host_side_model_inst (.clk_i, .line_in_n_o(line_n), .evt_o(evt), .wr_hit_o(wr_hit),
        .rd_hit_o(rd_hit));
    // Free-running 40 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        num_checks++;
        if ((got & m) !== (exp & m)) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_irq(input logic e);
        num_checks++;
        if (local_irq_o !== e) begin
            errors++;
            $display("mismatch at %0t: local irq %b", $time, local_irq_o);
        end
    endtask : chk_irq
    // A request stands for exactly one rising edge; a gap cycle follows.
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(negedge clk_i);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
        @(negedge clk_i);
        req = '0;
    endtask : wr
    // The answer is registered, so it is settled by the next falling edge.
    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(negedge clk_i);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: 32'h0000_0000};
        @(negedge clk_i);
        req = '0;
        chk({31'h0000_0000, rvalid_o}, 32'h0000_0001, 32'h0000_0001);
        chk(rdata_o, exp, m);
    endtask : rc
    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask : idle
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    // The tests need under a thousand cycles, so five thousand means a hang.
    initial begin
        #(25 * 5000);
        errors++;
        give_verdict();
    end
    // Main sequence.
    initial begin
        errors = 0;
        num_checks = 0;
        req = '0;
        sel = '0;
        srst_i = 1'b1;
        idle(12);
        srst_i = 1'b0;
        rc(8'h77, 32'h0000_0000, 32'hffff_0000);
        rc(8'hd0, 32'h0000_0000, 32'hffff_ffff);
        rc(8'h10, 32'h0000_0000, 32'hffff_ffff);
        $display("test reset done");
        wr(8'hd0, 4'h3, 32'h0000_0001);
        wr(8'hd0, 4'hc, 32'h8000_0000);
        rc(8'hd0, 32'h8000_0001, 32'hffff_ffff);
        rc(8'hd2, 32'h0000_8000, 32'h0000_ffff);
        wr(8'h77, 4'h8, 32'h8000_0000);
        host_side_model_inst.hit(1'b0, 1);
        idle(3);
        rc(8'h76, 32'h8000_0000, 32'hffff_0000);
        host_side_model_inst.hit(1'b1, 0);
        idle(3);
        rc(8'h76, 32'h8000_0000, 32'hffff_0000);
        chk_irq(1'b0);
        host_side_model_inst.hit(1'b0, 0);
        idle(3);
        rc(8'h76, 32'h8080_0000, 32'hffff_0000);
        chk_irq(1'b1);
        wr(8'h77, 4'h8, 32'h0000_0000);
        idle(2);
        chk_irq(1'b0);
        wr(8'hd8, 4'h3, 32'h0000_0000);
        rc(8'h76, 32'h0080_0000, 32'h0080_0000);
        wr(8'hd8, 4'h3, 32'h0000_0001);
        idle(2);
        rc(8'h76, 32'h0000_0000, 32'h0080_0000);
        host_side_model_inst.hit(1'b1, 15);
        idle(3);
        rc(8'hd8, 32'h8000_0000, 32'hffff_ffff);
        rc(8'hda, 32'h0000_8000, 32'hffff_ffff);
        rc(8'h76, 32'h0080_0000, 32'h0080_0000);
        wr(8'hda, 4'h3, 32'h0000_8000);
        rc(8'hda, 32'h0000_0000, 32'hffff_ffff);
        $display("test mailbox done");
        // Each event alone, first masked by every other bit, then unmasked.
        for (int b = 0; b < 7; b++) begin
            host_side_model_inst.set_lv(4'hf, 7'(1 << b));
            wr(8'h77, 4'h8, {~8'(1 << b), 24'h00_0000});
            idle(6);
            chk_irq(1'b0);
            wr(8'h77, 4'h8, {8'(1 << b), 24'h00_0000});
            idle(3);
            rc(8'h76, {8'(1 << b), 8'(1 << b), 16'h0000}, 32'hffff_0000);
            chk_irq(1'b1);
        end
        $display("test local events done");
        // Each path selected alone, with its source quiet and then active.
        for (int k = 0; k < 12; k++) begin
            sel = irq_route_pkg::route_sel_s'(12'(1) << (11 - k));
            host_side_model_inst.set_lv(4'hf, 7'h00);
            idle(6);
            rc(8'h48, 32'h0000_0000, 32'h0000_ffff);
            host_side_model_inst.set_lv(~(4'(1) << src_tbl[k]), 7'h00);
            wr(8'h48, 4'hf, 32'hffff_ffff);
            idle(6);
            rc(8'h48, 32'(1) << pos_tbl[k], 32'h0000_ffff);
        end
        $display("test routes done");
        give_verdict();
    end
endmodule : bridge_interrupt_routing_mask_tb
`default_nettype wire

// ### testbench/host_side_model.sv
// Model of the host and local processor that drive the block's event side.
`timescale 1ns/1ps
`default_nettype none
module host_side_model (
    input  wire logic                clk_i,
    output logic [3:0]               line_in_n_o,
    output irq_route_pkg::local_evt_s evt_o,
    output logic [15:0]              wr_hit_o,
    output logic [15:0]              rd_hit_o
);
    // Lines idle high through their pull-ups; nothing is pending at start.
    initial begin
        line_in_n_o = 4'hf;
        evt_o = '0;
        wr_hit_o = 16'h0000;
        rd_hit_o = 16'h0000;
    end
    // A mailbox access is a single-cycle pulse, launched off the sampling edge.
    task automatic hit(input logic is_rd, input int n);
        @(negedge clk_i);
        if (is_rd) rd_hit_o[n] = 1'b1;
        else wr_hit_o[n] = 1'b1;
        @(negedge clk_i);
        rd_hit_o = 16'h0000;
        wr_hit_o = 16'h0000;
    endtask : hit
    // Levels change only at falling edges, away from the design's sampling.
    task automatic set_lv(input logic [3:0] ln, input logic [6:0] ev);
        @(negedge clk_i);
        line_in_n_o = ln;
        evt_o = ev;
    endtask : set_lv
endmodule : host_side_model
`default_nettype wire

// ### testbench/irq_route_props.sv
// Checker for the bridge interrupt block, bound to its top-level ports.
`timescale 1ns/1ps
`default_nettype none
module irq_route_props (
    input wire logic                      clk_i,
    input wire logic                      srst_i,
    input wire irq_route_pkg::reg_req_s   req_i,
    input wire logic                      rvalid_o,
    input wire logic [31:0]               rdata_o,
    input wire irq_route_pkg::route_sel_s route_sel_i,
    input wire logic [3:0]                line_in_n_i,
    input wire irq_route_pkg::local_evt_s evt_i,
    input wire logic [15:0]               mbox_wr_hit_i,
    input wire logic [15:0]               mbox_rd_hit_i,
    input wire logic                      local_irq_o
);
    logic [7:0] addr_q;
    logic       on_route;
    logic       on_local;
    // An answer belongs to the address of the request one edge earlier.
    always_ff @(posedge clk_i) begin
        addr_q <= req_i.addr;
    end
    // Answers to reads of the route word and of the local word.
    assign on_route = rvalid_o && addr_q == 8'h48;
    assign on_local = rvalid_o && (addr_q == 8'h76 || addr_q == 8'h77);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_read_answer: assert property (req_i.rd |=> rvalid_o)
        else $error("read got no answer");
    a_no_stray: assert property (!req_i.rd |=> !rvalid_o && rdata_o == 32'h0000_0000)
        else $error("answer without a read");
    a_reserved_zero: assert property (on_route |-> !rdata_o[10] && !rdata_o[5] && !rdata_o[0])
        else $error("reserved route bit set");
    a_c_to_d_idle: assert property ((!route_sel_i.c_to_d)[*6] ##0 on_route |-> !rdata_o[14])
        else $error("unselected path shown");
    a_a_to_b_idle: assert property ((!route_sel_i.a_to_b)[*6] ##0 on_route |-> !rdata_o[4])
        else $error("unselected path shown");
    a_lines_idle: assert property ((line_in_n_i == 4'hf)[*6] ##0 on_route |-> rdata_o[15:0] == 16'h0000)
        else $error("route shown with quiet lines");
    a_irq_matches: assert property (on_local |-> local_irq_o == |(rdata_o[31:24] & rdata_o[23:16]))
        else $error("local irq disagrees with status and mask");
    // Reset itself is checked, so this one is never disabled.
    a_reset_quiet: assert property (disable iff (1'b0) srst_i |=> !rvalid_o && !local_irq_o)
        else $error("outputs active after reset");
    cover property (on_route && rdata_o[14]);
    cover property (|mbox_wr_hit_i ##3 local_irq_o);
    cover property (|evt_i ##[1:8] local_irq_o);
endmodule : irq_route_props
bind bridge_interrupt_routing_mask irq_route_props irq_route_props_inst (.clk_i, .srst_i, .req_i, .rvalid_o,
    .rdata_o, .route_sel_i, .line_in_n_i, .evt_i, .mbox_wr_hit_i, .mbox_rd_hit_i, .local_irq_o);
`default_nettype wire
